/* sgcs_bcast_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Broadcast block source on all ports
// ****************************************
module sgcs_bcast_src #(
  parameter int NPORT = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Burst request and length
  input wire logic go,
  input wire logic [7:0] nblk,
  // One block per cycle per port
  output logic [NPORT-1:0] bcast_blk
);
  logic [7:0] left_q; // Blocks still to send
  // Load on go, count down while busy
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      left_q <= 8'h00;
    end else if (go) begin
      left_q <= nblk;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  assign bcast_blk = (left_q != 8'h00) ? '1 : '0;
endmodule // sgcs_bcast_src
`default_nettype wire

/* sgcs_cfg.svh */
`ifndef SGCS_CFG_SVH
`define SGCS_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define SGCS_OFS_LINK_STORM_HI 8'h06
`define SGCS_OFS_STORM_LO 8'h07
`define SGCS_OFS_FTEST_A 8'h08
`define SGCS_OFS_FTEST_B 8'h09
`define SGCS_OFS_FTEST_C 8'h0a

// ****************************************
// Field positions in the link register
// ****************************************
`define SGCS_BIT_HALF_DUPLEX 6
`define SGCS_BIT_FLOW_CTRL 5
`define SGCS_BIT_SPEED_10 4
`define SGCS_BIT_NULL_VID 3
`define SGCS_STORM_HI_MSB 2
`define SGCS_STORM_W 11

// ****************************************
// Reset values
// ****************************************
`define SGCS_RST_NULL_VID 1'b0
`define SGCS_RST_STORM_HI 3'h0
`define SGCS_RST_STORM_LO 8'h4a
`define SGCS_RST_FTEST_A 8'h00
`define SGCS_RST_FTEST_B 8'h4c
`define SGCS_RST_FTEST_C 8'h00
`define SGCS_RST_UNMAPPED 8'h00

// ****************************************
// Timing
// ****************************************
`define SGCS_CLK_KHZ 200000
`define SGCS_PERIOD_100_MS 50
`define SGCS_PERIOD_10_MS 500
`define SGCS_PERIOD_100_CYC (`SGCS_PERIOD_100_MS * `SGCS_CLK_KHZ)
`define SGCS_PERIOD_10_CYC (`SGCS_PERIOD_10_MS * `SGCS_CLK_KHZ)

`endif

/* sgcs_global_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sgcs_cfg.svh"

// Behaviour
// - Bit 6 set selects half duplex
// - Duplex bit resets from duplex strap pin
// - Bit 5 set enables full-duplex flow control
// - Flow-control bit resets from its strap
// - Bit 4 set selects 10 Mbps
// - Speed bit resets from speed strap
// - Bit 3 replaces null VID with port VID
// - Two registers form one 11-bit limit
// - Period 50 ms at 100, 500 at 10
// - Storm limit resets to 0x04A
module sgcs_global_ctrl #(
  parameter int NPORT = 5,
  parameter int unsigned PERIOD_100_CYC = `SGCS_PERIOD_100_CYC,
  parameter int unsigned PERIOD_10_CYC = `SGCS_PERIOD_10_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Strap pins
  input wire logic duplex_strap_pin,
  input wire logic flow_ctrl_strap_pin,
  input wire logic speed_strap_pin,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // Host-facing switch port configuration, null VID enable and the shared storm limit
  output sgcs_pkg::sgcs_p5cfg_t host_facing_switch_port,
  output logic null_vid_repl_en,
  output logic [`SGCS_STORM_W-1:0] storm_limit,
  // Broadcast storm protection
  input wire logic [NPORT-1:0] bcast_blk,
  output logic [NPORT-1:0] bcast_pass,
  output logic [NPORT-1:0] bcast_drop,
  output logic period_start,
  // Null VID replacement path
  input wire sgcs_pkg::sgcs_tag_t tag_in,
  input wire logic [11:0] port_vid [NPORT],
  output sgcs_pkg::sgcs_tag_t tag_out
);

  // ****************************************
  // Period timer sizing
  // ****************************************
  // Counter must hold the longer of the two periods
  localparam int unsigned PER_MAX =
    (PERIOD_10_CYC > PERIOD_100_CYC) ? PERIOD_10_CYC : PERIOD_100_CYC;
  localparam int PER_W = $clog2(PER_MAX + 1);
  // Terminal counts, one per port speed
  localparam logic [PER_W-1:0] LAST_100 = PER_W'(PERIOD_100_CYC - 1);
  localparam logic [PER_W-1:0] LAST_10 = PER_W'(PERIOD_10_CYC - 1);

  // ****************************************
  // Strap synchronisation
  // ****************************************
  logic [2:0] strap_s; // Synchronised straps: duplex, flow, speed

  // Straps come from pins, two flops before use
  // The synchroniser has no reset of its own, so reset
  // must be held long enough for the straps to settle
  sgcs_strap_sync #(
    .W(3)
  ) u_strap_sync (
    .clk(clk),
    .pin_in({duplex_strap_pin, flow_ctrl_strap_pin, speed_strap_pin}),
    .pin_sync(strap_s)
  );

  // ****************************************
  // Register state
  // ****************************************
  // Link bits of the host-facing switch port
  logic half_q; // Half duplex select
  logic half_d;
  logic fc_q; // Flow control enable
  logic fc_d;
  logic spd10_q; // 10 Mbps select
  logic spd10_d;
  // Null VID enable and the storm limit
  logic nvid_q; // Null VID replacement enable
  logic nvid_d;
  logic [2:0] storm_hi_q; // Limit bits 10..8
  logic [2:0] storm_hi_d;
  logic [7:0] storm_lo_q; // Limit bits 7..0
  logic [7:0] storm_lo_d;
  // Read answer, held until the next read
  logic [7:0] rdata_q; // Read data holding register
  logic [7:0] rdata_d;
  logic rvalid_q; // Read answer pulse
  logic rvalid_d;
  logic [7:0] rd_mux; // Addressed register value

  // ****************************************
  // Register read path
  // ****************************************

  // Read multiplexer
  always_comb begin
    case (reg_addr)
      // Link bits and limit bits 10..8; bit 7 reads zero
      `SGCS_OFS_LINK_STORM_HI: begin
        rd_mux = 8'h00;
        rd_mux[`SGCS_BIT_HALF_DUPLEX] = half_q;
        rd_mux[`SGCS_BIT_FLOW_CTRL] = fc_q;
        rd_mux[`SGCS_BIT_SPEED_10] = spd10_q;
        rd_mux[`SGCS_BIT_NULL_VID] = nvid_q;
        rd_mux[`SGCS_STORM_HI_MSB:0] = storm_hi_q;
      end
      // Low byte of the limit
      `SGCS_OFS_STORM_LO: begin
        rd_mux = storm_lo_q;
      end
      // Factory test registers, constant
      `SGCS_OFS_FTEST_A: begin
        rd_mux = `SGCS_RST_FTEST_A;
      end
      `SGCS_OFS_FTEST_B: begin
        rd_mux = `SGCS_RST_FTEST_B;
      end
      `SGCS_OFS_FTEST_C: begin
        rd_mux = `SGCS_RST_FTEST_C;
      end
      // Anything else reads zero
      default: begin
        rd_mux = `SGCS_RST_UNMAPPED;
      end
    endcase
  end

  // ****************************************
  // Register write path
  // ****************************************
  // Next register values
  always_comb begin
    // Hold by default; the read answer is a pulse
    half_d = half_q;
    fc_d = fc_q;
    spd10_d = spd10_q;
    nvid_d = nvid_q;
    storm_hi_d = storm_hi_q;
    storm_lo_d = storm_lo_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (sys_rst) begin
      // Straps sampled while reset is held
      // Reloaded every reset cycle, so a late strap still lands
      half_d = strap_s[2];
      fc_d = strap_s[1];
      spd10_d = strap_s[0];
      nvid_d = `SGCS_RST_NULL_VID;
      storm_hi_d = `SGCS_RST_STORM_HI;
      storm_lo_d = `SGCS_RST_STORM_LO;
      rdata_d = 8'h00;
    end else begin
      // Writes; test registers and unmapped offsets ignore them
      if (reg_wr) begin
        case (reg_addr)
          // Link bits, null VID enable, limit bits 10..8
          `SGCS_OFS_LINK_STORM_HI: begin
            half_d = reg_wdata[`SGCS_BIT_HALF_DUPLEX];
            fc_d = reg_wdata[`SGCS_BIT_FLOW_CTRL];
            spd10_d = reg_wdata[`SGCS_BIT_SPEED_10];
            nvid_d = reg_wdata[`SGCS_BIT_NULL_VID];
            storm_hi_d = reg_wdata[`SGCS_STORM_HI_MSB:0];
          end
          // Low byte acts at once, no pairing with the high bits
          `SGCS_OFS_STORM_LO: begin
            storm_lo_d = reg_wdata;
          end
          // Test registers and unmapped offsets keep their values
          default: begin
            storm_lo_d = storm_lo_q;
          end
        endcase
      end
      // Reads answer one cycle later
      // A write in the same cycle is not yet visible to the read
      if (reg_rd) begin
        rdata_d = rd_mux;
        rvalid_d = 1'b1;
      end
    end
  end

  // Register update
  always_ff @(posedge clk) begin
    half_q <= half_d;
    fc_q <= fc_d;
    spd10_q <= spd10_d;
    nvid_q <= nvid_d;
    storm_hi_q <= storm_hi_d;
    storm_lo_q <= storm_lo_d;
    rdata_q <= rdata_d;
    rvalid_q <= rvalid_d;
  end

  // ****************************************
  // Configuration outputs
  // ****************************************
  // Levels straight from the register flops
  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign host_facing_switch_port.half_duplex = half_q;
  assign host_facing_switch_port.flow_ctrl_en = fc_q;
  assign host_facing_switch_port.speed_10 = spd10_q;
  assign null_vid_repl_en = nvid_q;
  assign storm_limit = {storm_hi_q, storm_lo_q};

  // ****************************************
  // Storm measurement period
  // ****************************************
  logic [PER_W-1:0] per_cnt_q; // Cycles into current period
  logic [PER_W-1:0] per_cnt_d;
  logic spd_seen_q; // Speed the period was started at
  logic spd_seen_d;
  logic pstart_q; // Period start pulse
  logic pstart_d;
  logic per_end; // Last cycle or speed change

  // Next timer values
  always_comb begin
    // Period length follows the port speed
    per_end = (per_cnt_q == (spd10_q ? LAST_10 : LAST_100))
      || (spd_seen_q != spd10_q);
    // Count on by default; remember the speed in use
    per_cnt_d = per_cnt_q + PER_W'(1);
    spd_seen_d = spd10_q;
    pstart_d = 1'b0;
    if (sys_rst) begin
      // Fresh period once reset is released
      per_cnt_d = '0;
      // Speed tracking keeps following the strapped speed, so
      // release does not look like a speed change
    end else if (per_end) begin
      // Restart, also on a speed change mid-period
      per_cnt_d = '0;
      pstart_d = 1'b1;
    end
  end

  // Timer registers
  always_ff @(posedge clk) begin
    per_cnt_q <= per_cnt_d;
    spd_seen_q <= spd_seen_d;
    pstart_q <= pstart_d;
  end

  // Pulse leaves a flop, one cycle wide
  assign period_start = pstart_q;

  // ****************************************
  // Per-port storm meters
  // ****************************************
  // One meter per input port
  // All meters share one period pulse and one limit
  for (genvar p = 0; p < NPORT; p++) begin : g_meter
    sgcs_storm_meter #(
      .LIM_W(`SGCS_STORM_W)
    ) u_meter (
      .clk(clk),
      .sys_rst(sys_rst),
      .period_start(pstart_q),
      .limit(storm_limit),
      .blk(bcast_blk[p]),
      .pass(bcast_pass[p]),
      .drop(bcast_drop[p])
    );
  end

  // ****************************************
  // Null VID replacement
  // ****************************************
  sgcs_pkg::sgcs_tag_t tag_q; // Registered tag out
  sgcs_pkg::sgcs_tag_t tag_d;

  // Substitute the ingress port's VID for a null one
  // Ports beyond NPORT have no default VID, tag passes as is
  always_comb begin
    tag_d = tag_in;
    if (sys_rst) begin
      tag_d = '0;
    end else if (nvid_q && tag_in.valid && (tag_in.vid == 12'h000)
                 && (int'(tag_in.port) < NPORT)) begin
      tag_d.vid = port_vid[tag_in.port];
    end
  end

  // Tag register
  always_ff @(posedge clk) begin
    tag_q <= tag_d;
  end

  assign tag_out = tag_q;

endmodule // sgcs_global_ctrl

`default_nettype wire

/* sgcs_global_ctrl_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Register bank checker
// ****************************************
module sgcs_global_ctrl_props #(
  parameter int NPORT = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  // Configuration outputs
  input wire sgcs_pkg::sgcs_p5cfg_t host_facing_switch_port,
  input wire logic null_vid_repl_en,
  input wire logic [10:0] storm_limit,
  // Storm meters and tags
  input wire logic [NPORT-1:0] bcast_blk,
  input wire logic [NPORT-1:0] bcast_pass,
  input wire logic [NPORT-1:0] bcast_drop,
  input wire logic period_start,
  input wire sgcs_pkg::sgcs_tag_t tag_in,
  input wire sgcs_pkg::sgcs_tag_t tag_out
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (sys_rst);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rd_idle_a: assert property (!reg_rd |=> !reg_rvalid)
    else $error("spurious read valid");
  ftest_b_a: assert property (reg_rd && reg_addr == 8'h09 |=> reg_rdata == 8'h4c)
    else $error("factory test b value");
  link_wr_a: assert property (reg_wr && reg_addr == 8'h06
    |=> host_facing_switch_port == $past(reg_wdata[6:4])) else $error("link bits");
  hi_wr_a: assert property (reg_wr && reg_addr == 8'h06
    |=> {null_vid_repl_en, storm_limit[10:8]} == $past(reg_wdata[3:0])) else $error("hi");
  lo_wr_a: assert property (reg_wr && reg_addr == 8'h07
    |=> storm_limit[7:0] == $past(reg_wdata)) else $error("limit low byte");
  rst_val_a: assert property ($fell(sys_rst)
    |-> storm_limit == 11'h04a && !null_vid_repl_en) else $error("reset values");
  blk_verdict_a: assert property (bcast_blk[0] |=> bcast_pass[0] != bcast_drop[0])
    else $error("no single verdict");
  zero_lim_a: assert property (bcast_blk[0] && storm_limit == 11'h000
    && $stable(storm_limit) |=> bcast_drop[0]) else $error("zero limit passed");
  tag_keep_a: assert property (tag_in.vid != 12'h000 |=> tag_out == $past(tag_in))
    else $error("tag altered");
  cover property (bcast_drop[0]);
  cover property (period_start);
  cover property (reg_rvalid && reg_rdata == 8'h4c);
endmodule // sgcs_global_ctrl_props
bind sgcs_global_ctrl sgcs_global_ctrl_props #(.NPORT(NPORT)) u_props (.clk(clk),
  .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .host_facing_switch_port(host_facing_switch_port), .null_vid_repl_en(null_vid_repl_en),
  .storm_limit(storm_limit), .bcast_blk(bcast_blk), .bcast_pass(bcast_pass),
  .bcast_drop(bcast_drop), .period_start(period_start), .tag_in(tag_in), .tag_out(tag_out));
`default_nettype wire

/* sgcs_pkg.sv */
`default_nettype none

package sgcs_pkg;

  // Host-facing switch port configuration
  typedef struct packed {
    logic half_duplex;  // 1 half, 0 full
    logic flow_ctrl_en; // Full-duplex flow control
    logic speed_10;     // 1 is 10 Mbps, 0 is 100 Mbps
  } sgcs_p5cfg_t;

  // Received VLAN tag as seen by the bank
  typedef struct packed {
    logic valid;
    logic [2:0] port;
    logic [11:0] vid;
  } sgcs_tag_t;

endpackage

`default_nettype wire

/* sgcs_storm_meter.sv */
`timescale 1ns/1ps
`default_nettype none

// Per-port broadcast block counter against the storm limit
module sgcs_storm_meter #(
  parameter int LIM_W = 11
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Period and limit
  input wire logic period_start,
  input wire logic [LIM_W-1:0] limit,
  // Broadcast 64-byte block offered
  input wire logic blk,
  // Verdicts, one-cycle pulses
  output logic pass,
  output logic drop
);

  logic [LIM_W-1:0] cnt_q; // Blocks accepted this period
  logic [LIM_W-1:0] cnt_d;
  logic pass_q;
  logic pass_d;
  logic drop_q;
  logic drop_d;
  logic room;

  // Next values
  always_comb begin
    room = (cnt_q < limit);
    cnt_d = cnt_q;
    pass_d = 1'b0;
    drop_d = 1'b0;
    if (sys_rst) begin
      cnt_d = '0;
    end else if (period_start) begin
      // New period; a block in this cycle is its first
      cnt_d = '0;
      if (blk && (limit != '0)) begin
        cnt_d = LIM_W'(1);
        pass_d = 1'b1;
      end else if (blk) begin
        drop_d = 1'b1;
      end
    end else if (blk && room) begin
      cnt_d = cnt_q + LIM_W'(1);
      pass_d = 1'b1;
    end else if (blk) begin
      drop_d = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    cnt_q <= cnt_d;
    pass_q <= pass_d;
    drop_q <= drop_d;
  end

  assign pass = pass_q;
  assign drop = drop_q;

endmodule // sgcs_storm_meter

`default_nettype wire

/* sgcs_strap_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for strap pins
module sgcs_strap_sync #(
  parameter int W = 3
) (
  // Clock
  input wire logic clk,
  // Pins and synchronised levels
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] pin_sync
);

  logic [W-1:0] meta_q; // First stage, read only by second
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q; // Second stage
  logic [W-1:0] sync_d;

  // Next values
  always_comb begin
    meta_d = pin_in;
    sync_d = meta_q;
  end

  // Registers
  always_ff @(posedge clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign pin_sync = sync_q;

endmodule // sgcs_strap_sync

`default_nettype wire

/* switch_global_ctrl_port5_storm_test.sv */
`timescale 1ns/1ps
`default_nettype none
module switch_global_ctrl_port5_storm_test;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  typedef struct packed {logic [7:0] a; logic [7:0] w; logic [7:0] r;} sgcs_row_t;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] strap = 3'b101; // Duplex, flow, speed
  logic reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_rvalid, null_vid_repl_en, period_start;
  logic [10:0] storm_limit;
  logic [4:0] blk, bcast_pass, bcast_drop;
  logic [11:0] port_vid [5];
  sgcs_pkg::sgcs_p5cfg_t hport;
  sgcs_pkg::sgcs_tag_t tag_in = '0, tag_out;
  int n_fail = 0, cmp_count = 0, np = 0, nd = 0, gap;
  // Write, read back value
  sgcs_row_t rows [8] = '{'{8'h06, 8'hff, 8'h7f}, '{8'h07, 8'h5a, 8'h5a},
    '{8'h08, 8'hff, 8'h00}, '{8'h09, 8'hff, 8'h4c}, '{8'h0a, 8'hff, 8'h00},
    '{8'h0b, 8'hff, 8'h00}, '{8'h20, 8'hff, 8'h00}, '{8'h06, 8'h00, 8'h00}};
  always #2.5 clk = ~clk;
  // Tally verdicts over all ports
  always @(posedge clk) begin
    np += $countones(bcast_pass);
    nd += $countones(bcast_drop);
  end
  initial foreach (port_vid[i]) port_vid[i] = 12'h100 + 12'(i);
  sgcs_global_ctrl #(.NPORT(5), .PERIOD_100_CYC(20), .PERIOD_10_CYC(200)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .duplex_strap_pin(strap[2]),
    .flow_ctrl_strap_pin(strap[1]), .speed_strap_pin(strap[0]), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .host_facing_switch_port(hport),
    .null_vid_repl_en(null_vid_repl_en), .storm_limit(storm_limit), .bcast_blk(blk),
    .bcast_pass(bcast_pass), .bcast_drop(bcast_drop), .period_start(period_start),
    .tag_in(tag_in), .port_vid(port_vid), .tag_out(tag_out));
  sgcs_bcast_src #(.NPORT(5)) u_src (.clk(clk), .sys_rst(sys_rst), .go(go),
    .nblk(8'h05), .bcast_blk(blk));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst(input logic [2:0] s);
    strap = s;
    sys_rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 sys_rst = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
    @(posedge clk);
    #1 reg_wr = 1'b0;
  endtask
  // Read strobe, answer one cycle later
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 {reg_rd, reg_addr} = {1'b1, a};
    @(posedge clk);
    #1 reg_rd = 1'b0;
    chk({7'h00, reg_rvalid, reg_rdata}, {8'h01, e});
  endtask
  // Cycles until next period pulse
  task automatic wps(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1 n++;
    end while (period_start !== 1'b1 && n < 400);
  endtask
  task automatic burst;
    np = 0;
    nd = 0;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic tg(input logic [2:0] p, input logic [11:0] v, input logic [11:0] e);
    @(posedge clk);
    #1 tag_in = '{valid: 1'b1, port: p, vid: v};
    @(posedge clk);
    #1 chk(16'(tag_out.vid), 16'(e));
    tag_in = '0;
  endtask
  task automatic results;
    $display("checks=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst(3'b101);
    chk(16'(hport), 16'h0005);
    chk(16'(storm_limit), 16'h004a);
    foreach (rows[i]) begin
      if (rows[i].a < 8'h08 || rows[i].a > 8'h0a) wr(rows[i].a, rows[i].w);
      rd(rows[i].a, rows[i].r);
    end
    chk(16'(storm_limit), 16'h005a);
    wr(8'h07, 8'h03);
    wps(gap);
    wps(gap);
    chk(16'(gap), 16'h0014);
    burst;
    chk({8'(np), 8'(nd)}, 16'h0f0a);
    wr(8'h07, 8'h00);
    wr(8'h06, 8'h10);
    chk(16'(hport), 16'h0001);
    wps(gap);
    wps(gap);
    chk(16'(gap), 16'h00c8);
    burst;
    chk({8'(np), 8'(nd)}, 16'h0019);
    wr(8'h06, 8'h08);
    tg(3'h2, 12'h000, 12'h102);
    tg(3'h2, 12'h005, 12'h005);
    tg(3'h7, 12'h000, 12'h000);
    wr(8'h06, 8'h00);
    tg(3'h2, 12'h000, 12'h000);
    rst(3'b010);
    chk(16'(hport), 16'h0002);
    results;
  end
  // Watchdog against a hung wait
  initial begin
    #20000;
    n_fail++;
    results;
  end
endmodule // switch_global_ctrl_port5_storm_test
`default_nettype wire
